/* File: verilog/elc_pkg.sv */
/*
  Constants for the E1 link error counter bank: microport pages and
  addresses, counter layout, interrupt mask placement, reset values.
  Assumes a byte-wide paged microport synchronous to the framing clock.
*/
package elc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CNT = 9;
  localparam int NUM_IRQ = 8;
  localparam int NUM_MSK = 5;
  localparam int NUM_SNAP = 4;
  localparam int PAGE_W = 5;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int INC_W = 3;

  // ----------------------------------------------------------------
  // Counter indices (0..7 also index the overflow latch bits)
  // ----------------------------------------------------------------
  localparam int CI_PRBS = 0;
  localparam int CI_EBIT = 1;
  localparam int CI_JFIFO = 2;
  localparam int CI_SYNC = 3;
  localparam int CI_BITERR = 4;
  localparam int CI_EFAS = 5;
  localparam int CI_BPV = 6;
  localparam int CI_CRC = 7;
  localparam int CI_MF = 8;

  // ----------------------------------------------------------------
  // Pages and addresses
  // ----------------------------------------------------------------
  localparam logic [PAGE_W-1:0] PG_CTRL = 5'h01;
  localparam logic [PAGE_W-1:0] PG_CNT = 5'h04;
  localparam logic [PAGE_W-1:0] PG_SEC = 5'h09;
  localparam logic [ADDR_W-1:0] HI_NONE = 5'h00;
  localparam logic [ADDR_W-1:0] CNT_LO_ADDR [NUM_CNT] =
    '{5'h10, 5'h13, 5'h15, 5'h17, 5'h18, 5'h1A, 5'h1C, 5'h1E, 5'h11};
  localparam logic [ADDR_W-1:0] CNT_HI_ADDR [NUM_CNT] =
    '{5'h00, 5'h14, 5'h00, 5'h00, 5'h00, 5'h00, 5'h1D, 5'h1F, 5'h00};
  localparam logic [CNT_W-1:0] CNT_MAX [NUM_CNT] =
    '{16'h00FF, 16'h03FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
      16'hFFFF, 16'h03FF, 16'h00FF};
  localparam logic [ADDR_W-1:0] ADDR_OVL = 5'h16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h1A;
  localparam int CLR_BIT = 2;

  // Mask words: 19H, 1BH, 1CH, 1DH, and an auxiliary word at 12H
  localparam logic [ADDR_W-1:0] MSK_ADDR [NUM_MSK] =
    '{5'h19, 5'h1B, 5'h1C, 5'h1D, 5'h12};
  localparam int EVT_MREG [NUM_IRQ] = '{0, 2, 4, 4, 2, 1, 2, 2};
  localparam int EVT_MBIT [NUM_IRQ] = '{5, 7, 0, 2, 1, 2, 4, 6};
  localparam int OVF_MREG [NUM_IRQ] = '{0, 3, 4, 4, 3, 3, 1, 3};
  localparam int OVF_MBIT [NUM_IRQ] = '{6, 7, 1, 3, 2, 4, 1, 6};

  // One-second page copies these counters
  localparam int SNAP_IDX [NUM_SNAP] = '{1, 5, 6, 7};

  // ----------------------------------------------------------------
  // Reset and idle values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_NONE = 8'h00;

endpackage : elc_pkg

/* File: verilog/elc_counter_bank.sv */
/*
  E1 link error counter bank: nine event counters with preset, global
  clear, overflow latch, one-second snapshot page and masked interrupt
  pulses. Event inputs and the microport come from logic on CLK_I;
  nothing here is resynchronised.
*/
`timescale 1ns/1ps

// What this block does
// - Every counter presettable or clearable by microport write
// - One-second pulse copies four counters to status page
// - Each counter except the multiframe counter has maskable event and overflow interrupts
// - Global clear bit forces and holds counters zero
// - Overflow latch bits set, cleared by reading
// - PRBS error counter counts received sequence errors
// - Writing PRBS error counter clears multiframe counter
// - Multiframe counter counts multiframes, directly loadable
// - PRBS overflow interrupt masked by national-use word
// - Ten-bit E-bit counter over two byte locations
// - E-bit interrupts on LSB toggle and overflow
// - Jitter FIFO counter counts near-slip margin events
// - Loadable counter counts basic frame alignment losses
// - Counts each errored bit of alignment word
// - Bit-error interrupts on LSB toggle and FFH wrap
// - Counts alignment words holding any bit error
// - Frame-error interrupts on LSB toggle and wrap
// - Sixteen-bit counter counts bipolar violations
// - Violation interrupts on LSB toggle and FFFFH wrap
// - Ten-bit checksum error counter over two bytes
// - Checksum interrupts on LSB toggle and overflow
module elc_counter_bank (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // Microport
  input wire logic [elc_pkg::PAGE_W-1:0] UP_PAGE_I,
  input wire logic [elc_pkg::ADDR_W-1:0] UP_ADDR_I,
  input wire logic UP_WR_I,
  input wire logic UP_RD_I,
  input wire logic [elc_pkg::DATA_W-1:0] UP_WDATA_I,
  output logic [elc_pkg::DATA_W-1:0] UP_RDATA_O,
  output logic UP_RVALID_O,
  // Error events from the receive path
  input wire logic PRBS_ERR_I,
  input wire logic MULTIFRAME_I,
  input wire logic EBIT_ERR_I,
  input wire logic JFIFO_MARGIN_I,
  input wire logic FRAME_LOSS_I,
  input wire logic [elc_pkg::INC_W-1:0] FAS_BIT_ERRS_I,
  input wire logic FAS_ERR_I,
  input wire logic BPV_I,
  input wire logic CRC_ERR_I,
  input wire logic ONE_SEC_I,
  // Interrupt pulses
  output logic [elc_pkg::NUM_IRQ-1:0] EVENT_IRQ_O,
  output logic [elc_pkg::NUM_IRQ-1:0] OVERFLOW_IRQ_O
);

  // ----------------------------------------------------------------
  // Shared signals
  // ----------------------------------------------------------------
  logic [elc_pkg::CNT_W-1:0] cnt_q [elc_pkg::NUM_CNT];
  logic [elc_pkg::INC_W-1:0] inc [elc_pkg::NUM_CNT];
  logic [elc_pkg::NUM_CNT-1:0] ovf_vec;
  logic [elc_pkg::NUM_CNT-1:0] tgl_vec;
  logic [elc_pkg::DATA_W-1:0] msk_q [elc_pkg::NUM_MSK];
  logic [elc_pkg::DATA_W-1:0] msk_d [elc_pkg::NUM_MSK];
  logic [elc_pkg::DATA_W-1:0] ctrl_q;
  logic [elc_pkg::DATA_W-1:0] ctrl_d;
  logic clr_all;
  logic wr_cnt;
  logic prbs_wr;
  logic ovl_rd;

  assign clr_all = ctrl_q[elc_pkg::CLR_BIT];
  assign wr_cnt = UP_WR_I && (UP_PAGE_I == elc_pkg::PG_CNT);
  assign prbs_wr = wr_cnt &&
    (UP_ADDR_I == elc_pkg::CNT_LO_ADDR[elc_pkg::CI_PRBS]);
  assign ovl_rd = UP_RD_I && (UP_PAGE_I == elc_pkg::PG_CNT) &&
    (UP_ADDR_I == elc_pkg::ADDR_OVL);

  // ----------------------------------------------------------------
  // Event steering
  // ----------------------------------------------------------------
  always_comb begin
    inc[elc_pkg::CI_PRBS] = {2'b00, PRBS_ERR_I};
    inc[elc_pkg::CI_EBIT] = {2'b00, EBIT_ERR_I};
    inc[elc_pkg::CI_JFIFO] = {2'b00, JFIFO_MARGIN_I};
    inc[elc_pkg::CI_SYNC] = {2'b00, FRAME_LOSS_I};
    inc[elc_pkg::CI_BITERR] = FAS_BIT_ERRS_I;
    inc[elc_pkg::CI_EFAS] = {2'b00, FAS_ERR_I};
    inc[elc_pkg::CI_BPV] = {2'b00, BPV_I};
    inc[elc_pkg::CI_CRC] = {2'b00, CRC_ERR_I};
    inc[elc_pkg::CI_MF] = {2'b00, MULTIFRAME_I};
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Writes win over a same-cycle event; that event is not counted.
  for (genvar gi = 0; gi < elc_pkg::NUM_CNT; gi++) begin : g_cnt
    logic [elc_pkg::CNT_W-1:0] q;
    logic [elc_pkg::CNT_W-1:0] d;
    logic [elc_pkg::CNT_W:0] sum;
    logic of;
    logic wr_lo;
    logic wr_hi;
    assign wr_lo = wr_cnt && (UP_ADDR_I == elc_pkg::CNT_LO_ADDR[gi]);
    assign wr_hi = wr_cnt && (elc_pkg::CNT_HI_ADDR[gi] != elc_pkg::HI_NONE)
      && (UP_ADDR_I == elc_pkg::CNT_HI_ADDR[gi]);
    always_comb begin
      sum = {1'b0, q} + {14'h0, inc[gi]};
      d = q;
      of = 1'b0;
      if (clr_all) begin
        d = elc_pkg::CNT_RST;
      end else if (wr_lo) begin
        d = {q[15:8], UP_WDATA_I} & elc_pkg::CNT_MAX[gi];
      end else if (wr_hi) begin
        d = {UP_WDATA_I, q[7:0]} & elc_pkg::CNT_MAX[gi];
      end else if ((gi == elc_pkg::CI_MF) && prbs_wr) begin
        d = elc_pkg::CNT_RST;
      end else if (inc[gi] != 3'h0) begin
        d = sum[15:0] & elc_pkg::CNT_MAX[gi];
        of = sum > {1'b0, elc_pkg::CNT_MAX[gi]};
      end
    end
    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
        q <= elc_pkg::CNT_RST;
      end else if (CE_I) begin
        q <= d;
      end
    end
    assign cnt_q[gi] = q;
    assign ovf_vec[gi] = of;
    assign tgl_vec[gi] = d[0] ^ q[0];
  end

  // ----------------------------------------------------------------
  // Control and mask words
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    for (int m = 0; m < elc_pkg::NUM_MSK; m++) begin
      msk_d[m] = msk_q[m];
      if (UP_WR_I && (UP_PAGE_I == elc_pkg::PG_CTRL) &&
          (UP_ADDR_I == elc_pkg::MSK_ADDR[m])) begin
        msk_d[m] = UP_WDATA_I;
      end
    end
    if (UP_WR_I && (UP_PAGE_I == elc_pkg::PG_CTRL) &&
        (UP_ADDR_I == elc_pkg::ADDR_CTRL)) begin
      ctrl_d = UP_WDATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= elc_pkg::REG_RST;
      for (int m = 0; m < elc_pkg::NUM_MSK; m++) begin
        msk_q[m] <= elc_pkg::REG_RST;
      end
    end else if (CE_I) begin
      ctrl_q <= ctrl_d;
      for (int m = 0; m < elc_pkg::NUM_MSK; m++) begin
        msk_q[m] <= msk_d[m];
      end
    end
  end

  // ----------------------------------------------------------------
  // Overflow latch, interrupts, snapshot, read data
  // ----------------------------------------------------------------
  logic [elc_pkg::NUM_IRQ-1:0] ovl_q;
  logic [elc_pkg::NUM_IRQ-1:0] ovl_d;
  logic [elc_pkg::NUM_IRQ-1:0] evt_d;
  logic [elc_pkg::NUM_IRQ-1:0] ovi_d;
  logic [elc_pkg::NUM_IRQ-1:0] evt_en;
  logic [elc_pkg::NUM_IRQ-1:0] ovf_en;
  logic [elc_pkg::CNT_W-1:0] snap_q [elc_pkg::NUM_SNAP];
  logic [elc_pkg::CNT_W-1:0] snap_d [elc_pkg::NUM_SNAP];
  logic [elc_pkg::DATA_W-1:0] rd_d;

  always_comb begin
    // A new overflow in the read cycle survives the clear
    ovl_d = (ovl_rd ? '0 : ovl_q) |
      ovf_vec[elc_pkg::NUM_IRQ-1:0];
    for (int j = 0; j < elc_pkg::NUM_IRQ; j++) begin
      evt_en[j] = msk_q[elc_pkg::EVT_MREG[j]][elc_pkg::EVT_MBIT[j]];
      ovf_en[j] = msk_q[elc_pkg::OVF_MREG[j]][elc_pkg::OVF_MBIT[j]];
      evt_d[j] = tgl_vec[j] && evt_en[j];
      ovi_d[j] = ovf_vec[j] && ovf_en[j];
    end
    for (int k = 0; k < elc_pkg::NUM_SNAP; k++) begin
      snap_d[k] = ONE_SEC_I ? cnt_q[elc_pkg::SNAP_IDX[k]] :
        snap_q[k];
    end
  end

  always_comb begin
    rd_d = elc_pkg::RD_NONE;
    case (UP_PAGE_I)
      elc_pkg::PG_CNT: begin
        for (int i = 0; i < elc_pkg::NUM_CNT; i++) begin
          if (UP_ADDR_I == elc_pkg::CNT_LO_ADDR[i]) begin
            rd_d = cnt_q[i][7:0];
          end
          if ((elc_pkg::CNT_HI_ADDR[i] != elc_pkg::HI_NONE) &&
              (UP_ADDR_I == elc_pkg::CNT_HI_ADDR[i])) begin
            rd_d = cnt_q[i][15:8];
          end
        end
        if (UP_ADDR_I == elc_pkg::ADDR_OVL) begin
          rd_d = ovl_q;
        end
      end
      elc_pkg::PG_SEC: begin
        for (int k = 0; k < elc_pkg::NUM_SNAP; k++) begin
          if (UP_ADDR_I == elc_pkg::CNT_LO_ADDR[elc_pkg::SNAP_IDX[k]]) begin
            rd_d = snap_q[k][7:0];
          end
          if ((elc_pkg::CNT_HI_ADDR[elc_pkg::SNAP_IDX[k]] != elc_pkg::HI_NONE)
              && (UP_ADDR_I == elc_pkg::CNT_HI_ADDR[elc_pkg::SNAP_IDX[k]]))
          begin
            rd_d = snap_q[k][15:8];
          end
        end
      end
      elc_pkg::PG_CTRL: begin
        for (int m = 0; m < elc_pkg::NUM_MSK; m++) begin
          if (UP_ADDR_I == elc_pkg::MSK_ADDR[m]) begin
            rd_d = msk_q[m];
          end
        end
        if (UP_ADDR_I == elc_pkg::ADDR_CTRL) begin
          rd_d = ctrl_q;
        end
      end
      default: begin
        rd_d = elc_pkg::RD_NONE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ovl_q <= '0;
      EVENT_IRQ_O <= '0;
      OVERFLOW_IRQ_O <= '0;
      UP_RDATA_O <= elc_pkg::RD_NONE;
      UP_RVALID_O <= 1'b0;
      for (int k = 0; k < elc_pkg::NUM_SNAP; k++) begin
        snap_q[k] <= elc_pkg::CNT_RST;
      end
    end else if (CE_I) begin
      ovl_q <= ovl_d;
      EVENT_IRQ_O <= evt_d;
      OVERFLOW_IRQ_O <= ovi_d;
      UP_RVALID_O <= UP_RD_I;
      if (UP_RD_I) begin
        UP_RDATA_O <= rd_d;
      end
      for (int k = 0; k < elc_pkg::NUM_SNAP; k++) begin
        snap_q[k] <= snap_d[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  logic all_zero;
  always_comb begin
    all_zero = 1'b1;
    for (int i = 0; i < elc_pkg::NUM_CNT; i++) begin
      if (cnt_q[i] != elc_pkg::CNT_RST) begin
        all_zero = 1'b0;
      end
    end
  end

  clear_hold_a: assert property (
    CE_I && clr_all |=> all_zero)
    else $error("counters not held at zero under clear");

  preset_load_a: assert property (
    CE_I && !clr_all && wr_cnt &&
    (UP_ADDR_I == elc_pkg::CNT_LO_ADDR[elc_pkg::CI_JFIFO])
    |=> cnt_q[elc_pkg::CI_JFIFO][7:0] == $past(UP_WDATA_I))
    else $error("counter preset not loaded");

  prbs_count_a: assert property (
    CE_I && !clr_all && !wr_cnt && PRBS_ERR_I &&
    cnt_q[elc_pkg::CI_PRBS] < elc_pkg::CNT_MAX[elc_pkg::CI_PRBS]
    |=> cnt_q[elc_pkg::CI_PRBS] == $past(cnt_q[elc_pkg::CI_PRBS]) + 16'h0001)
    else $error("prbs error counter did not advance by one");

  mf_clear_a: assert property (
    CE_I && !clr_all && prbs_wr |=> cnt_q[elc_pkg::CI_MF] == elc_pkg::CNT_RST)
    else $error("multiframe counter not cleared by prbs write");

  ovl_set_a: assert property (
    CE_I && ovf_vec[elc_pkg::CI_EFAS]
    |=> ovl_q[elc_pkg::CI_EFAS] ##1 (ovl_q[elc_pkg::CI_EFAS] || $past(ovl_rd)))
    else $error("overflow latch bit lost before a read");

  ovl_read_a: assert property (
    CE_I && ovl_rd && (ovf_vec[elc_pkg::NUM_IRQ-1:0] == '0) |=> ovl_q == '0)
    else $error("overflow latch not cleared by read");

  ber_wrap_a: assert property (
    CE_I && !clr_all && !wr_cnt &&
    cnt_q[elc_pkg::CI_BITERR] == elc_pkg::CNT_MAX[elc_pkg::CI_BITERR] &&
    FAS_BIT_ERRS_I == 3'h1
    |=> cnt_q[elc_pkg::CI_BITERR] == elc_pkg::CNT_RST &&
        ovl_q[elc_pkg::CI_BITERR])
    else $error("bit error counter did not wrap FFH to 00H");

  bpv_wrap_a: assert property (
    CE_I && !clr_all && !wr_cnt && BPV_I &&
    cnt_q[elc_pkg::CI_BPV] == elc_pkg::CNT_MAX[elc_pkg::CI_BPV] &&
    ovf_en[elc_pkg::CI_BPV]
    |=> cnt_q[elc_pkg::CI_BPV] == elc_pkg::CNT_RST &&
        OVERFLOW_IRQ_O[elc_pkg::CI_BPV])
    else $error("violation counter wrap without overflow interrupt");

  ebit_event_a: assert property (
    CE_I && tgl_vec[elc_pkg::CI_EBIT] && evt_en[elc_pkg::CI_EBIT]
    |=> EVENT_IRQ_O[elc_pkg::CI_EBIT])
    else $error("e-bit event interrupt missing on toggle");

  irq_masked_a: assert property (
    CE_I && !ovf_en[elc_pkg::CI_PRBS]
    |=> !OVERFLOW_IRQ_O[elc_pkg::CI_PRBS])
    else $error("masked prbs overflow interrupt fired");

  snap_copy_a: assert property (
    CE_I && ONE_SEC_I
    |=> snap_q[3] == $past(cnt_q[elc_pkg::CI_CRC]) &&
        snap_q[0] == $past(cnt_q[elc_pkg::CI_EBIT]))
    else $error("one-second page did not copy counters");

  ebit_wrap_a: assert property (
    CE_I && !clr_all && !wr_cnt && EBIT_ERR_I &&
    cnt_q[elc_pkg::CI_EBIT] == elc_pkg::CNT_MAX[elc_pkg::CI_EBIT]
    |=> cnt_q[elc_pkg::CI_EBIT] == elc_pkg::CNT_RST &&
        ovl_q[elc_pkg::CI_EBIT])
    else $error("e-bit counter did not wrap at ten bits");

  ebit_hi_load_a: assert property (
    CE_I && !clr_all && wr_cnt &&
    (UP_ADDR_I == elc_pkg::CNT_HI_ADDR[elc_pkg::CI_EBIT])
    |=> cnt_q[elc_pkg::CI_EBIT][15:8] ==
        ($past(UP_WDATA_I) & elc_pkg::CNT_MAX[elc_pkg::CI_EBIT][15:8]))
    else $error("e-bit high byte not loaded");

  efas_wrap_a: assert property (
    CE_I && !clr_all && !wr_cnt && FAS_ERR_I &&
    cnt_q[elc_pkg::CI_EFAS] == elc_pkg::CNT_MAX[elc_pkg::CI_EFAS] &&
    ovf_en[elc_pkg::CI_EFAS]
    |=> cnt_q[elc_pkg::CI_EFAS] == elc_pkg::CNT_RST &&
        OVERFLOW_IRQ_O[elc_pkg::CI_EFAS])
    else $error("frame error wrap without overflow interrupt");

  crc_event_a: assert property (
    CE_I && tgl_vec[elc_pkg::CI_CRC] && evt_en[elc_pkg::CI_CRC]
    |=> EVENT_IRQ_O[elc_pkg::CI_CRC])
    else $error("checksum event interrupt missing on toggle");

  sync_count_a: assert property (
    CE_I && !clr_all && !wr_cnt && FRAME_LOSS_I
    |=> cnt_q[elc_pkg::CI_SYNC] == (($past(cnt_q[elc_pkg::CI_SYNC]) +
        16'h0001) & elc_pkg::CNT_MAX[elc_pkg::CI_SYNC]))
    else $error("sync loss counter did not advance by one");

  cover_wrap_c: cover property (ovf_vec[elc_pkg::CI_BPV]);
  cover_snap_c: cover property (ONE_SEC_I && cnt_q[elc_pkg::CI_CRC] != 16'h0);
  cover_rdclr_c: cover property (ovl_rd && ovl_q != '0);
  cover_clear_c: cover property (clr_all ##1 !clr_all ##[1:4] !all_zero);

endmodule // elc_counter_bank

/* File: dv/elc_counter_bank_bench.sv */
/*
  Self-checking bench for the E1 link error counter bank.
  Assumes elc_pkg and elc_counter_bank; one clock, bench drives all ports.
*/
`timescale 1ns/1ps
module elc_counter_bank_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rst, ce, wr_s, rd_s, rvalid, one_sec, clr_on;
  logic [elc_pkg::PAGE_W-1:0] page;
  logic [elc_pkg::ADDR_W-1:0] addr;
  logic [elc_pkg::DATA_W-1:0] wdata, rdata, b;
  logic [elc_pkg::NUM_CNT-1:0] ev;
  logic [elc_pkg::INC_W-1:0] fas_bits;
  logic [elc_pkg::NUM_IRQ-1:0] ev_irq, ov_irq;
  logic [15:0] model [elc_pkg::NUM_CNT];
  logic [15:0] snap [elc_pkg::NUM_SNAP];
  logic [15:0] v;
  int ev_seen [elc_pkg::NUM_IRQ];
  int ov_seen [elc_pkg::NUM_IRQ];
  int errors, n_checks, seed, cycles, e0, o0;

  elc_counter_bank u_elc_counter_bank (
    .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce),
    .UP_PAGE_I(page), .UP_ADDR_I(addr), .UP_WR_I(wr_s), .UP_RD_I(rd_s),
    .UP_WDATA_I(wdata), .UP_RDATA_O(rdata), .UP_RVALID_O(rvalid),
    .PRBS_ERR_I(ev[0]), .MULTIFRAME_I(ev[8]), .EBIT_ERR_I(ev[1]),
    .JFIFO_MARGIN_I(ev[2]), .FRAME_LOSS_I(ev[3]),
    .FAS_BIT_ERRS_I(fas_bits), .FAS_ERR_I(ev[5]), .BPV_I(ev[6]),
    .CRC_ERR_I(ev[7]), .ONE_SEC_I(one_sec),
    .EVENT_IRQ_O(ev_irq), .OVERFLOW_IRQ_O(ov_irq)
  );

  // ----------------------------------------------------------------
  // Clock, interrupt pulse tally, hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Pulses last one cycle; sampled at the falling edge, where settled
  always @(negedge clk) begin
    cycles++;
    for (int j = 0; j < elc_pkg::NUM_IRQ; j++) begin
      if (ev_irq[j] === 1'b1) ev_seen[j]++;
      if (ov_irq[j] === 1'b1) ov_seen[j]++;
    end
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------
  task automatic summarize();
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] bump(int i, int amt);
    return (model[i] + 16'(amt)) & elc_pkg::CNT_MAX[i];
  endfunction

  task automatic wr(input logic [4:0] pg, input logic [4:0] a,
                    input logic [7:0] d);
    @(negedge clk);
    page = pg;
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask

  // Data without the valid pulse reads as unknown and so mismatches
  task automatic rd(input logic [4:0] pg, input logic [4:0] a,
                    output logic [7:0] d);
    @(negedge clk);
    page = pg;
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask

  task automatic set_cnt(input int i, input logic [15:0] val);
    model[i] = val & elc_pkg::CNT_MAX[i];
    wr(elc_pkg::PG_CNT, elc_pkg::CNT_LO_ADDR[i], model[i][7:0]);
    if (elc_pkg::CNT_HI_ADDR[i] != elc_pkg::HI_NONE)
      wr(elc_pkg::PG_CNT, elc_pkg::CNT_HI_ADDR[i], model[i][15:8]);
    if (i == elc_pkg::CI_PRBS) model[elc_pkg::CI_MF] = 16'h0000;
  endtask

  task automatic get_cnt(input logic [4:0] pg, input int i);
    v = 16'h0000;
    rd(pg, elc_pkg::CNT_LO_ADDR[i], v[7:0]);
    if (elc_pkg::CNT_HI_ADDR[i] != elc_pkg::HI_NONE)
      rd(pg, elc_pkg::CNT_HI_ADDR[i], v[15:8]);
  endtask

  // n back-to-back event cycles; the bit-error counter adds k per cycle
  task automatic pulse(input int i, input int n, input logic [2:0] k);
    @(negedge clk);
    if (i == elc_pkg::CI_BITERR) fas_bits = k;
    else ev[i] = 1'b1;
    repeat (n) @(negedge clk);
    ev = '0;
    fas_bits = '0;
    if (!clr_on) model[i] = bump(i, (i == elc_pkg::CI_BITERR) ? n * k : n);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, ce, wr_s, rd_s, one_sec, clr_on} = 6'b110000;
    page = '0;
    addr = '0;
    wdata = '0;
    ev = '0;
    fas_bits = '0;
    {errors, n_checks, cycles} = '0;
    seed = 24;
    foreach (model[i]) model[i] = 16'h0000;
    foreach (ev_seen[j]) {ev_seen[j], ov_seen[j]} = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < elc_pkg::NUM_CNT; i++) begin
      get_cnt(elc_pkg::PG_CNT, i);
      check(v, 16'h0000);
    end
    rd(elc_pkg::PG_CNT, 5'h0B, b);
    check(16'(b), 16'h0000);
    // Random presets then random counting bursts on every counter
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < elc_pkg::NUM_CNT; i++) begin
        set_cnt(i, 16'($random(seed)));
        get_cnt(elc_pkg::PG_CNT, i);
        check(v, model[i]);
        pulse(i, 1 + ($random(seed) & 7), 3'($random(seed)) | 3'h1);
        get_cnt(elc_pkg::PG_CNT, i);
        check(v, model[i]);
      end
      set_cnt(elc_pkg::CI_PRBS, 16'h0000);
      get_cnt(elc_pkg::PG_CNT, elc_pkg::CI_MF);
      check(v, 16'h0000);
    end
    // Wrap every counter except the multiframe counter with all interrupts enabled
    for (int m = 0; m < elc_pkg::NUM_MSK; m++) begin
      wr(elc_pkg::PG_CTRL, elc_pkg::MSK_ADDR[m], 8'hFF);
      rd(elc_pkg::PG_CTRL, elc_pkg::MSK_ADDR[m], b);
      check(16'(b), 16'h00FF);
    end
    rd(elc_pkg::PG_CNT, elc_pkg::ADDR_OVL, b);
    for (int i = 0; i < elc_pkg::NUM_IRQ; i++) begin
      set_cnt(i, elc_pkg::CNT_MAX[i]);
      repeat (3) @(negedge clk);
      e0 = ev_seen[i];
      o0 = ov_seen[i];
      pulse(i, 1, 3'h1);
      repeat (2) @(negedge clk);
      check(16'(ev_seen[i]-e0), 16'h0001);
      check(16'(ov_seen[i] - o0), 16'h0001);
      get_cnt(elc_pkg::PG_CNT, i);
      check(v, 16'h0000);
      rd(elc_pkg::PG_CNT, elc_pkg::ADDR_OVL, b);
      check(16'(b), 16'(1 << i));
      rd(elc_pkg::PG_CNT, elc_pkg::ADDR_OVL, b);
      check(16'(b), 16'h0000);
    end
    // Masked: latch still records the wrap, no interrupt pulses
    for (int m = 0; m < elc_pkg::NUM_MSK; m++)
      wr(elc_pkg::PG_CTRL, elc_pkg::MSK_ADDR[m], 8'h00);
    set_cnt(elc_pkg::CI_BPV, 16'hFFFF);
    e0 = ev_seen[6] + ov_seen[6];
    pulse(elc_pkg::CI_BPV, 1, 3'h1);
    repeat (2) @(negedge clk);
    check(16'(ev_seen[6] + ov_seen[6] - e0), 16'h0000);
    rd(elc_pkg::PG_CNT, elc_pkg::ADDR_OVL, b);
    check(16'(b), 16'h0040);
    // Events with the clock enable low are not taken
    ce = 1'b0;
    ev[6] = 1'b1;
    @(negedge clk);
    ev = '0;
    ce = 1'b1;
    get_cnt(elc_pkg::PG_CNT, elc_pkg::CI_BPV);
    check(v, model[6]);
    // Global clear forces zero and holds it against events
    wr(elc_pkg::PG_CTRL, elc_pkg::ADDR_CTRL, 8'h04);
    rd(elc_pkg::PG_CTRL, elc_pkg::ADDR_CTRL, b);
    check(16'(b), 16'h0004);
    clr_on = 1'b1;
    foreach (model[i]) model[i] = 16'h0000;
    for (int i = 0; i < elc_pkg::NUM_CNT; i++) begin
      pulse(i, 3, 3'h7);
      get_cnt(elc_pkg::PG_CNT, i);
      check(v, 16'h0000);
    end
    wr(elc_pkg::PG_CTRL, elc_pkg::ADDR_CTRL, 8'h00);
    clr_on = 1'b0;
    pulse(elc_pkg::CI_CRC, 2, 3'h1);
    get_cnt(elc_pkg::PG_CNT, elc_pkg::CI_CRC);
    check(v, 16'h0002);
    // One-second page keeps values from the tick, not later counts
    for (int s = 0; s < elc_pkg::NUM_SNAP; s++) begin
      set_cnt(elc_pkg::SNAP_IDX[s], 16'($random(seed)));
      snap[s] = model[elc_pkg::SNAP_IDX[s]];
    end
    @(negedge clk);
    one_sec = 1'b1;
    @(negedge clk);
    one_sec = 1'b0;
    for (int s = 0; s < elc_pkg::NUM_SNAP; s++) begin
      pulse(elc_pkg::SNAP_IDX[s], 1, 3'h1);
      get_cnt(elc_pkg::PG_SEC, elc_pkg::SNAP_IDX[s]);
      check(v, snap[s]);
    end
    // Mid-run reset returns counters, masks and snapshots to zero
    wr(elc_pkg::PG_CTRL, elc_pkg::MSK_ADDR[0], 8'hFF);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    get_cnt(elc_pkg::PG_CNT, elc_pkg::CI_BPV);
    check(v, 16'h0000);
    rd(elc_pkg::PG_CTRL, elc_pkg::MSK_ADDR[0], b);
    check(16'(b), 16'h0000);
    get_cnt(elc_pkg::PG_SEC, elc_pkg::CI_CRC);
    check(v, 16'h0000);
    summarize();
  end
endmodule // elc_counter_bank_bench
